// ===== hdl/pt16_timer.sv
// Prescaled 16-bit timer/counter with AXI4-Lite register slave
//
// Contract
// - Main count advances once per prescale limit plus one clock cycles.
// - At prescale limit, next clock bumps main count and clears prescaler.
// - Prescale count is 16 bits, readable and writable by software anytime.
// - Control register at 0x004 disables counting or holds counters reset.
// - Flag register reports five pending sources; writes clear pending flags.
// - Each of four matches may reset count, stop counters, or interrupt.
// - Capture control selects capture edges and whether capture interrupts.
// - Selected capture edge copies main count into read-only capture register.
// - External match register drives match pins; three or two per instance.
// - Count source register picks timer or counter mode and counted edges.
// - PWM control register switches individual match pins to PWM.
// - Every implemented register bit reads zero after reset.
// - Two instances share offsets, based at 0x4000C000 and 0x40010000.
// - Writing one clears a flag, zero leaves it; bits 0-3 match, 4 capture.
// - Main count wraps from 0xFFFF to zero without any interrupt.
// - Control bit 0 enables counters; bit 1 holds both synchronously reset.
// - Stop on match halts counters and clears the enable bit.
`include "pt16_map.svh"

module pt16_timer
    import pt16_pkg::*;
#(
    parameter logic [31:0] BASE_ADDR = `PT_BASE_FIRST,
    parameter int unsigned NPINS     = 3
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [31:0]      awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [31:0]      araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    input  wire logic             capture_input,
    output logic [NPINS-1:0]      match_pins,
    output logic                  irq
);

    // ============================================================
    // Bus slave state
    logic        aw_hold_r, aw_hold_nxt, aw_hit_r, aw_hit_nxt;
    logic [11:0] aw_ofs_r, aw_ofs_nxt;
    logic        w_hold_r, w_hold_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        awready_r, awready_nxt, wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic        arready_r, arready_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        do_wr, wr_ok, ar_hit;
    logic [11:0] wofs;
    logic [31:0] wmask, wv;

    // ============================================================
    // Timer state
    logic [1:0]  tctl_r, tctl_nxt;
    logic [15:0] mcount_r, mcount_nxt, pcount_r, pcount_nxt;
    logic [15:0] plimit_r, plimit_nxt, capval_r, capval_nxt;
    logic [15:0] mval_r [4];
    logic [15:0] mval_nxt [4];
    logic [11:0] mact_r, mact_nxt, extmc_r, extmc_nxt;
    logic [2:0]  capctl_r, capctl_nxt;
    logic [3:0]  csrc_r, csrc_nxt, pwmc_r, pwmc_nxt;
    logic [4:0]  imask_r, imask_nxt, flags_r, flags_nxt;
    logic [4:0]  fset, fclr;
    logic [3:0]  eq, eq_d_r, evt, rst_hit, stop_hit;
    logic [NPINS-1:0] pins_r, pins_nxt;
    logic        irq_r, irq_nxt;
    logic        cap_s1_r, cap_s2_r, cap_s3_r;
    logic        cap_rise, cap_fall, cap_evt, cnt_ev, tick, stop_now;
    pt_capctl_t  cc;
    pt_match_t   mact_ch [4];

    assign awready    = awready_r;
    assign wready     = wready_r;
    assign bvalid     = bvalid_r;
    assign bresp      = bresp_r;
    assign arready    = arready_r;
    assign rvalid     = rvalid_r;
    assign rdata      = rdata_r;
    assign rresp      = rresp_r;
    assign match_pins = pins_r;
    assign irq        = irq_r;

    // Write fires once address and data are both held and no answer waits
    assign do_wr  = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wr_ok  = do_wr & aw_hit_r;
    assign wofs   = {aw_ofs_r[11:2], 2'b00};
    assign ar_hit = (araddr & `PT_BASE_MASK) == BASE_ADDR;
    assign wmask  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                     {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    // Read view of every register; reserved and unmapped words read zero
    function automatic logic [31:0] rmux(input logic [11:0] o);
        logic [31:0] v;
        v = 32'h00000000;
        case ({o[11:2], 2'b00})
            `PT_IFLAGS: v = {27'h0000000, flags_r};
            `PT_TCTRL:  v = {30'h00000000, tctl_r};
            `PT_MCOUNT: v = {16'h0000, mcount_r};
            `PT_PLIMIT: v = {16'h0000, plimit_r};
            `PT_PCOUNT: v = {16'h0000, pcount_r};
            `PT_MACT:   v = {20'h00000, mact_r};
            `PT_MVAL0:  v = {16'h0000, mval_r[0]};
            `PT_MVAL1:  v = {16'h0000, mval_r[1]};
            `PT_MVAL2:  v = {16'h0000, mval_r[2]};
            `PT_MVAL3:  v = {16'h0000, mval_r[3]};
            `PT_CAPCTL: v = {29'h00000000, capctl_r};
            `PT_CAPVAL: v = {16'h0000, capval_r};
            `PT_EXTMC:  v = {20'h00000, extmc_r};
            `PT_CSRC:   v = {28'h0000000, csrc_r};
            `PT_PWMC:   v = {28'h0000000, pwmc_r};
            `PT_IMASK:  v = {27'h0000000, imask_r};
            default:    v = 32'h00000000;
        endcase
        return v;
    endfunction

    // ============================================================
    // AXI4-Lite channels: address and data may arrive in either order
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        aw_hit_nxt  = aw_hit_r;
        aw_ofs_nxt  = aw_ofs_r;
        w_hold_nxt  = w_hold_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (awvalid && awready_r) begin
            aw_hold_nxt = 1'b1;
            aw_hit_nxt  = (awaddr & `PT_BASE_MASK) == BASE_ADDR;
            aw_ofs_nxt  = awaddr[11:0];
        end
        if (wvalid && wready_r) begin
            w_hold_nxt = 1'b1;
            wdata_nxt  = wdata;
            wstrb_nxt  = wstrb;
        end
        if (do_wr) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = aw_hit_r ? `PT_RESP_OK : `PT_RESP_ERR;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = ar_hit ? rmux(araddr[11:0]) : 32'h00000000;
            rresp_nxt  = ar_hit ? `PT_RESP_OK : `PT_RESP_ERR;
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        // One item per channel is held; ready drops while it waits
        awready_nxt = ~aw_hold_nxt;
        wready_nxt  = ~w_hold_nxt;
        arready_nxt = ~rvalid_nxt;
    end

    // Bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_hold_r, aw_hit_r, w_hold_r, bvalid_r, rvalid_r} <= 5'h00;
            {awready_r, wready_r, arready_r} <= 3'h0;
            {aw_ofs_r, wstrb_r, bresp_r, rresp_r} <= 20'h00000;
            wdata_r   <= 32'h00000000;
            rdata_r   <= 32'h00000000;
        end else begin
            {aw_hold_r, aw_hit_r, w_hold_r, bvalid_r, rvalid_r} <=
                {aw_hold_nxt, aw_hit_nxt, w_hold_nxt, bvalid_nxt, rvalid_nxt};
            {awready_r, wready_r, arready_r} <=
                {awready_nxt, wready_nxt, arready_nxt};
            {aw_ofs_r, wstrb_r, bresp_r, rresp_r} <=
                {aw_ofs_nxt, wstrb_nxt, bresp_nxt, rresp_nxt};
            wdata_r   <= wdata_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ============================================================
    // Count and capture events from the synchronised capture input
    assign cc       = pt_capctl_t'(capctl_r);
    assign cap_rise = cap_s2_r & ~cap_s3_r;
    assign cap_fall = ~cap_s2_r & cap_s3_r;
    assign cap_evt  = (cc.rise & cap_rise) | (cc.fall & cap_fall);

    // Counter mode counts capture edges instead of clock cycles
    always_comb begin
        case (pt_cmode_t'(csrc_r[1:0]))
            PT_TIMER: cnt_ev = 1'b1;
            PT_RISE:  cnt_ev = cap_rise;
            PT_FALL:  cnt_ev = cap_fall;
            PT_BOTH:  cnt_ev = cap_rise | cap_fall;
            default:  cnt_ev = 1'b0;
        endcase
    end

    // Match compare; an event is the cycle where equality first appears
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            mact_ch[n]  = pt_match_t'(mact_r[3*n +: 3]);
            eq[n]       = mcount_r == mval_r[n];
            evt[n]      = eq[n] & ~eq_d_r[n] & tctl_r[`PT_TC_EN];
            rst_hit[n]  = eq[n] & mact_ch[n].rst;
            stop_hit[n] = evt[n] & mact_ch[n].stop;
            fset[n]     = evt[n] & mact_ch[n].irq;
        end
        fset[`PT_IF_CAP] = cap_evt & cc.irq;
    end

    assign stop_now = |stop_hit;
    // Stopping wins over counting in the very cycle of the match
    assign tick = tctl_r[`PT_TC_EN] & ~tctl_r[`PT_TC_RST] & cnt_ev
                & ~stop_now;

    // ============================================================
    // Timer next state: hardware first, software writes override data
    always_comb begin
        tctl_nxt   = tctl_r;
        mcount_nxt = mcount_r;
        pcount_nxt = pcount_r;
        plimit_nxt = plimit_r;
        mact_nxt   = mact_r;
        mval_nxt   = mval_r;
        capctl_nxt = capctl_r;
        capval_nxt = capval_r;
        extmc_nxt  = extmc_r;
        csrc_nxt   = csrc_r;
        pwmc_nxt   = pwmc_r;
        imask_nxt  = imask_r;
        fclr       = 5'h00;
        wv         = (rmux(wofs) & ~wmask) | (wdata_r & wmask);
        // Prescaler and main count
        if (tctl_r[`PT_TC_RST]) begin
            mcount_nxt = 16'h0000;
            pcount_nxt = 16'h0000;
        end else if (tick) begin
            if (pcount_r == plimit_r) begin
                pcount_nxt = 16'h0000;
                // Natural 16-bit wrap, no flag raised
                mcount_nxt = (|rst_hit) ? 16'h0000
                           : mcount_r + 16'h0001;
            end else begin
                pcount_nxt = pcount_r + 16'h0001;
            end
        end
        if (cap_evt) begin
            capval_nxt = mcount_r;
        end
        // Match pin states follow their programmed action
        for (int n = 0; n < 4; n++) begin
            if (evt[n]) begin
                case (pt_emact_t'(extmc_r[`PT_EM_CTL + 2*n +: 2]))
                    PT_EM_CLR: extmc_nxt[n] = 1'b0;
                    PT_EM_SET: extmc_nxt[n] = 1'b1;
                    PT_EM_TGL: extmc_nxt[n] = ~extmc_r[n];
                    default:   extmc_nxt[n] = extmc_r[n];
                endcase
            end
        end
        if (wr_ok) begin
            case (wofs)
                `PT_IFLAGS: fclr       = wdata_r[4:0] & wmask[4:0];
                `PT_TCTRL:  tctl_nxt   = wv[1:0];
                `PT_MCOUNT: mcount_nxt = wv[15:0];
                `PT_PLIMIT: plimit_nxt = wv[15:0];
                `PT_PCOUNT: pcount_nxt = wv[15:0];
                `PT_MACT:   mact_nxt   = wv[11:0];
                `PT_MVAL0:  mval_nxt[0] = wv[15:0];
                `PT_MVAL1:  mval_nxt[1] = wv[15:0];
                `PT_MVAL2:  mval_nxt[2] = wv[15:0];
                `PT_MVAL3:  mval_nxt[3] = wv[15:0];
                `PT_CAPCTL: capctl_nxt = wv[2:0];
                `PT_EXTMC:  extmc_nxt  = wv[11:0];
                `PT_CSRC:   csrc_nxt   = wv[3:0];
                `PT_PWMC:   pwmc_nxt   = wv[3:0];
                `PT_IMASK:  imask_nxt  = wv[4:0];
                default:    fclr       = 5'h00;
            endcase
        end
        if (stop_now) begin
            tctl_nxt[`PT_TC_EN] = 1'b0;
        end
        // A new event beats a clear in the same cycle
        flags_nxt = (flags_r & ~fclr) | fset;
        for (int n = 0; n < NPINS; n++) begin
            pins_nxt[n] = pwmc_r[n] ? (mcount_r >= mval_r[n])
                                    : extmc_r[n];
        end
        irq_nxt = |(flags_nxt & imask_nxt);
    end

    // Timer registers, all cleared by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tctl_r   <= 2'h0;
            {mcount_r, pcount_r, plimit_r, capval_r} <= 64'h0000000000000000;
            {mact_r, extmc_r} <= 24'h000000;
            mval_r   <= '{default: 16'h0000};
            {capctl_r, csrc_r, pwmc_r} <= 11'h000;
            {imask_r, flags_r, eq_d_r} <= 14'h0000;
            {cap_s1_r, cap_s2_r, cap_s3_r} <= 3'h0;
            pins_r   <= '0;
            irq_r    <= 1'b0;
        end else begin
            tctl_r   <= tctl_nxt;
            mcount_r <= mcount_nxt;
            pcount_r <= pcount_nxt;
            plimit_r <= plimit_nxt;
            mact_r   <= mact_nxt;
            mval_r   <= mval_nxt;
            capctl_r <= capctl_nxt;
            capval_r <= capval_nxt;
            extmc_r  <= extmc_nxt;
            csrc_r   <= csrc_nxt;
            pwmc_r   <= pwmc_nxt;
            imask_r  <= imask_nxt;
            flags_r  <= flags_nxt;
            eq_d_r   <= eq;
            pins_r   <= pins_nxt;
            irq_r    <= irq_nxt;
            // Pin is asynchronous: two sync stages, then the edge stage
            {cap_s3_r, cap_s2_r, cap_s1_r} <= {cap_s2_r, cap_s1_r, capture_input};
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_presc_clear: assert property (
        tick && pcount_r == plimit_r && !do_wr |=> pcount_r == 16'h0000)
        else $error("prescale count not cleared at limit");
    chk_main_step: assert property (
        tick && pcount_r == plimit_r && !do_wr && !(|rst_hit)
        |=> mcount_r == $past(mcount_r) + 16'h0001)
        else $error("main count did not step at prescale limit");
    chk_hold_reset: assert property (
        tctl_r[`PT_TC_RST] && !do_wr
        |=> mcount_r == 16'h0000 && pcount_r == 16'h0000)
        else $error("counters not held in reset");
    chk_disabled_hold: assert property (
        !tctl_r[`PT_TC_EN] && !tctl_r[`PT_TC_RST] && !do_wr
        |=> $stable(mcount_r) && $stable(pcount_r))
        else $error("disabled counters moved");
    chk_stop_clear: assert property (
        stop_now |=> !tctl_r[`PT_TC_EN]
        ##1 ($stable(mcount_r) || $past(wr_ok)))
        else $error("stop on match did not halt");
    chk_flag_sticky: assert property (
        !do_wr |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("flag lost without a write");
    chk_capture_load: assert property (
        cap_evt |=> capval_r == $past(mcount_r))
        else $error("capture did not load main count");
    chk_irq_level: assert property (
        irq_r == |(flags_r & imask_r))
        else $error("interrupt output disagrees with flags");
    chk_wrap_zero: assert property (
        tick && mcount_r == 16'hFFFF && pcount_r == plimit_r && !do_wr
        && !(|rst_hit) |=> mcount_r == 16'h0000)
        else $error("main count did not wrap");
    chk_match_reset: assert property (
        tick && pcount_r == plimit_r && (|rst_hit) && !do_wr
        |=> mcount_r == 16'h0000)
        else $error("reset on match missed");
    chk_rsv_zero: assert property (
        arvalid && arready_r && ar_hit && araddr[11:0] >= `PT_RSV_LO
        && araddr[11:0] <= `PT_RSV_HI |=> rvalid_r && rdata_r == 32'h0)
        else $error("reserved read not zero");

    cov_match_irq: cover property (evt[0] && fset[0] ##1 irq_r);
    cov_capture:   cover property (cap_evt ##1 flags_r[`PT_IF_CAP]);
    cov_stop:      cover property (stop_now ##1 !tctl_r[`PT_TC_EN]);
    cov_wrap:      cover property (mcount_r == 16'hFFFF ##1
                                   mcount_r == 16'h0000);

endmodule // pt16_timer

// ===== shared/pt16_map.svh
// Register offsets, field positions, reset values and addresses of pt16
`ifndef PT16_MAP_SVH
`define PT16_MAP_SVH

// ============================================================
// Register offsets inside one instance window
`define PT_IFLAGS    12'h000
`define PT_TCTRL     12'h004
`define PT_MCOUNT    12'h008
`define PT_PLIMIT    12'h00C
`define PT_PCOUNT    12'h010
`define PT_MACT      12'h014
`define PT_MVAL0     12'h018
`define PT_MVAL1     12'h01C
`define PT_MVAL2     12'h020
`define PT_MVAL3     12'h024
`define PT_CAPCTL    12'h028
`define PT_CAPVAL    12'h02C
`define PT_EXTMC     12'h03C
`define PT_RSV_LO    12'h040
`define PT_RSV_HI    12'h06C
`define PT_CSRC      12'h070
`define PT_PWMC      12'h074
`define PT_IMASK     12'h078

// ============================================================
// Instance base addresses and window decode
`define PT_BASE_FIRST  32'h4000C000
`define PT_BASE_SECOND 32'h40010000
`define PT_BASE_MASK   32'hFFFFF000

// ============================================================
// Field positions and reset value
`define PT_TC_EN     0
`define PT_TC_RST    1
`define PT_IF_CAP    4
`define PT_EM_CTL    4
`define PT_RST_VAL   32'h00000000
`define PT_RESP_OK   2'h0
`define PT_RESP_ERR  2'h2

`endif

// ===== shared/pt16_pkg.sv
// Types shared by the pt16 timer/counter
package pt16_pkg;

    // ============================================================
    // Count source selection
    typedef enum logic [1:0] {
        PT_TIMER = 2'b00,
        PT_RISE  = 2'b01,
        PT_FALL  = 2'b10,
        PT_BOTH  = 2'b11
    } pt_cmode_t;

    // Action taken on an external match pin at a match
    typedef enum logic [1:0] {
        PT_EM_NONE = 2'b00,
        PT_EM_CLR  = 2'b01,
        PT_EM_SET  = 2'b10,
        PT_EM_TGL  = 2'b11
    } pt_emact_t;

    // Per-channel match actions, interrupt in the low bit
    typedef struct packed {
        logic stop;
        logic rst;
        logic irq;
    } pt_match_t;

    // Capture control fields
    typedef struct packed {
        logic irq;
        logic fall;
        logic rise;
    } pt_capctl_t;

endpackage

// ===== testbench/pt16_pin_model.sv
// Far-side pin model: capture source and match pin observer for pt16
module pt16_pin_model (
    input  wire logic       aclk,
    input  wire logic [2:0] match_pins,
    output logic            capture_input
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pin idles low until a scenario asks for an edge
    initial capture_input = 1'b0;

    // Change the pin, then hold it long enough for sync and edge detect
    task automatic drive(input logic v);
        @(posedge aclk);
        capture_input <= v;
        repeat (8) @(posedge aclk);
    endtask
endmodule // pt16_pin_model

// ===== testbench/tb.sv
// Self-checking bench for the pt16 timer/counter
`include "pt16_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BASE = `PT_BASE_FIRST;
    localparam logic [31:0] BAD  = 32'h50000000;
    localparam logic [11:0] OFFS [17] = '{12'h000, 12'h004, 12'h008,
        12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C, 12'h020, 12'h024,
        12'h028, 12'h02C, 12'h03C, 12'h040, 12'h070, 12'h074, 12'h078};
    logic [31:0] awaddr, wdata, araddr, rdata, pv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        capture_input, irq;
    logic [2:0]  match_pins;
    logic [34:0] exp_q[$];
    int          num_errors, total_checks, cyc, t0, e;

    pt16_timer #(.BASE_ADDR(BASE), .NPINS(3)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .capture_input(capture_input), .match_pins(match_pins),
        .irq(irq));
    pt16_pin_model pm (.aclk(aclk), .match_pins(match_pins),
        .capture_input(capture_input));

    // ========================================
    // Clock and hang guard
    initial aclk = 1'b0;
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ========================================
    // Checking helpers
    task automatic miss(string m);
        num_errors++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic cmp(logic [34:0] g, logic [34:0] x, string m);
        total_checks++;
        if (g !== x) miss(m);
    endtask
    task automatic cmp_pop(logic [34:0] g);
        if (exp_q.size() == 0) miss("bus result with no note");
        else cmp(g, exp_q.pop_front(), "bus result");
    endtask
    // Oldest note is matched to each response as it is taken
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready) cmp_pop({1'b1, bresp, 32'h0});
        if (rvalid === 1'b1 && rready) cmp_pop({1'b0, rresp, rdata});
    end

    // ========================================
    // AXI4-Lite master; address and data are released independently
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [31:0] b = BASE);
        logic ad, wd;
        ad = 0;
        wd = 0;
        exp_q.push_back({1'b1, (b == BASE) ? `PT_RESP_OK : `PT_RESP_ERR,
                         32'h0});
        @(posedge aclk);
        awaddr <= b + a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] x, logic [31:0] b = BASE);
        exp_q.push_back({1'b0, (b == BASE) ? `PT_RESP_OK : `PT_RESP_ERR, x});
        @(posedge aclk);
        araddr <= b + a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    task automatic done(string n);
        repeat (2) @(posedge aclk);
        $display("test %s finished", n);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        void'($urandom(77222));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (OFFS[i]) rd(OFFS[i], 32'h0);
        cmp({irq, match_pins}, 0, "pins after reset");
        done("reset");
        // Refused and ignored places leave state alone
        pv = $urandom();
        wr(`PT_RSV_LO, pv);
        rd(`PT_RSV_LO, 32'h0);
        wr(`PT_PLIMIT, pv, BAD);
        rd(`PT_PLIMIT, 32'h0, BAD);
        wr(`PT_PCOUNT, pv);
        rd(`PT_PCOUNT, pv & 32'hFFFF);
        rd(`PT_PLIMIT, 32'h0);
        done("access");
        // Prescaled run up to a stop-and-interrupt match
        pv = $urandom_range(5, 2);
        wr(`PT_PCOUNT, 0);
        wr(`PT_PLIMIT, pv);
        wr(`PT_MVAL0, 20);
        wr(`PT_MACT, 32'h5);
        wr(`PT_IMASK, 32'h1F);
        wr(`PT_TCTRL, 32'h1);
        t0 = cyc;
        e = 20 * (int'(pv) + 1);
        while (irq !== 1'b1) @(posedge aclk);
        cmp(cyc - t0 >= e - 3 && cyc - t0 <= e + 3, 1, "period");
        rd(`PT_MCOUNT, 20);
        rd(`PT_TCTRL, 0);
        rd(`PT_IFLAGS, 1);
        wr(`PT_IMASK, 0);
        done("mask");
        cmp(irq, 0, "masked irq");
        wr(`PT_IMASK, 32'h1F);
        wr(`PT_IFLAGS, 0);
        rd(`PT_IFLAGS, 1);
        wr(`PT_IFLAGS, 1);
        rd(`PT_IFLAGS, 0);
        cmp(irq, 0, "cleared irq");
        done("prescale");
        // Wrap past the top value is silent; reset bit holds counts at zero
        wr(`PT_MACT, 32'h4);
        wr(`PT_MCOUNT, 32'hFFFF);
        wr(`PT_PLIMIT, 0);
        wr(`PT_MVAL0, 1);
        wr(`PT_TCTRL, 32'h1);
        repeat (10) @(posedge aclk);
        rd(`PT_MCOUNT, 1);
        rd(`PT_IFLAGS, 0);
        wr(`PT_TCTRL, 32'h3);
        repeat (6) @(posedge aclk);
        rd(`PT_MCOUNT, 0);
        rd(`PT_PCOUNT, 0);
        wr(`PT_TCTRL, 0);
        done("wrap");
        // Capture on rising edge only, with interrupt
        pv = $urandom_range(16'hFFF0, 2);
        wr(`PT_MCOUNT, pv);
        wr(`PT_CAPCTL, 32'h5);
        pm.drive(1'b1);
        rd(`PT_CAPVAL, pv);
        rd(`PT_IFLAGS, 32'h10);
        wr(`PT_CAPVAL, 0);
        wr(`PT_IFLAGS, 32'h10);
        wr(`PT_MCOUNT, 1);
        pm.drive(1'b0);
        rd(`PT_CAPVAL, pv);
        rd(`PT_IFLAGS, 0);
        done("capture");
        // Counter mode for each edge selection
        wr(`PT_CAPCTL, 0);
        wr(`PT_MACT, 0);
        for (int m = 1; m < 4; m++) begin
            wr(`PT_TCTRL, 32'h2);
            wr(`PT_CSRC, m);
            wr(`PT_TCTRL, 32'h1);
            repeat (3) begin
                pm.drive(1'b1);
                pm.drive(1'b0);
            end
            rd(`PT_MCOUNT, (m == 3) ? 6 : 3);
        end
        wr(`PT_TCTRL, 0);
        done("counter");
        // Pin levels from the external match register, then PWM on pin 0
        wr(`PT_EXTMC, 32'h5);
        done("pins");
        cmp(match_pins, 3'b101, "match pins");
        wr(`PT_EXTMC, 0);
        wr(`PT_MCOUNT, 5);
        wr(`PT_PWMC, 1);
        done("pwm");
        cmp(match_pins, 3'b001, "pwm high");
        // Set-on-match action drives pin 1, then the stop holds the count
        wr(`PT_CSRC, 0);
        wr(`PT_PWMC, 0);
        wr(`PT_EXTMC, 32'h80);
        wr(`PT_MVAL1, 8);
        wr(`PT_MACT, 32'h20);
        wr(`PT_TCTRL, 32'h1);
        repeat (8) @(posedge aclk);
        cmp(match_pins, 3'b010, "set on match");
        rd(`PT_EXTMC, 32'h82);
        rd(`PT_MCOUNT, 8);
        done("match set");
        report_and_stop();
    end
endmodule // tb
